// *** core/autoreclose_sequencer.sv ***
// Purpose: automatic reclosing sequencer, up to five shots, four request lines
// Assumes: settings are static inputs in 10 ms ticks; breaker feedback is async
// Notes: events are one-cycle pulses gated by their enables
// Behaviour
// R1 - one dead interval per shot, shared by all lines, default 5.00 s
// R2 - per shot, each line has an enable deciding if it starts the shot
// R3 - per line per shot start delay, default 0.02 s, before opening; only shot one's delays are used, later shots open at once
// R4 - per line per shot discrimination interval, default 0.02 s, after reclose
// R5 - six individually enabled events, default off
// R6 - three final trip events individually enabled, default on
// R7 - report current shot number, one to five
// R8 - count failed shots and total sequence starts
// R9 - per shot start counters for lines one and two
// R10 - request begins the first shot's start delay of its line
// R11 - on start delay expiry assert open command until breaker open
// R12 - breaker open releases open command, starts dead interval
// R13 - dead interval expiry asserts close command until breaker closed
// R14 - breaker closed releases close command, starts discrimination
// R15 - fault still present after discrimination reopens, next enabled shot
// R16 - fault cleared runs reclaim, then success and back to shot one
// R17 - reclaim 0.02-300 s default 10 s; manual close reclaim ignores requests
// R18 - simultaneous expiry picks line one first, line four last
// R19 - final trip sets the causing line's signal for 0.5 s
// R20 - critical request final trips in dead or discrimination, else ignored
// R21 - state indication of ten states
// R22 - indicate running or last interval kind
`timescale 1ns/1ps
`default_nettype none
`include "autoreclose_defs.svh"
module autoreclose_sequencer #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES // clocks per 10 ms tick
) (
  input wire logic ref_clk, // 250 MHz clock
  input wire logic rstn, // async reset, active low
  input wire logic function_enable, // function on
  input wire logic [3:0] request_lines, // request_line_one..request_line_four, async
  input wire logic critical_request, // critical request, async
  input wire logic breaker_is_open, // position feedback, async
  input wire logic breaker_is_closed, // position feedback, async
  input wire logic manual_close, // manual close pulse, same clock
  input wire logic [79:0] shot_dead_interval, // 5 x 16 ticks
  input wire logic [19:0] shot_line_enable, // 5 x 4 enables
  input wire logic [319:0] line_start_delay, // shot*4+line x 16 ticks
  input wire logic [319:0] line_discrim_interval, // shot*4+line x 16 ticks
  input wire logic [15:0] reclaim_interval, // reclaim ticks
  input wire logic [5:0] soft_event_enable, // crit end, release, stop, ft ready, on, off
  input wire logic [2:0] trip_event_enable, // critical, line one, line two
  output logic breaker_open_cmd, // open the breaker
  output logic breaker_close_cmd, // close the breaker
  output autoreclose_pkg::ar_state_e state_ind, // state indication
  output autoreclose_pkg::timer_kind_e timer_kind, // running or last interval
  output logic [2:0] shot_number, // current shot 1..5
  output logic [15:0] total_start_counter, // sequence starts
  output logic [15:0] fail_counter, // failed shots
  output logic [79:0] line_one_shot_counts, // 5 x 16 starts
  output logic [79:0] line_two_shot_counts, // 5 x 16 starts
  output logic [4:0] final_trip_sig, // lines 1..4 then critical
  output logic critical_end_event, // event pulse
  output logic release_event, // event pulse
  output logic stopped_event, // event pulse
  output logic final_trip_ready_event, // event pulse
  output logic function_enabled_event, // event pulse
  output logic function_disabled_event, // event pulse
  output logic critical_final_trip_event, // event pulse
  output logic line_one_final_trip_event, // event pulse
  output logic line_two_final_trip_event // event pulse
);
  import autoreclose_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers: first stage read only by second
  logic [6:0] sync1_q, sync2_q;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
    end
    else
    begin
      sync1_q <= {breaker_is_closed, breaker_is_open, critical_request, request_lines};
      sync2_q <= sync1_q;
    end
  end
  logic [3:0] req;
  logic crit, cb_open, cb_closed;
  assign req = sync2_q[3:0];
  assign crit = sync2_q[4];
  assign cb_open = sync2_q[5];
  assign cb_closed = sync2_q[6];

  ////////////////////////////////////////////////////////////////////////////
  // time base and start timers
  tick_if tk ();
  tick_divider #(.TICK_CYCLES(TICK_CYCLES)) u_div (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .tk(tk)
  );

  ar_state_e st_q, st_d;
  logic [2:0] shot_q, shot_d; // zero-based shot index
  ticks_t tmr_q, tmr_d;
  logic [1:0] line_q, line_d;
  timer_kind_e kind_q, kind_d;
  logic manual_q, manual_d;
  logic [7:0] ft_cnt_q, ft_cnt_d;
  logic [4:0] ft_q, ft_d;
  logic [15:0] starts_q, starts_d, fails_q, fails_d;
  logic [15:0] cnt1_q [5];
  logic [15:0] cnt1_d [5];
  logic [15:0] cnt2_q [5];
  logic [15:0] cnt2_d [5];
  logic [8:0] ev_q, ev_d;
  logic ena_q, crit_q;

  logic fire;
  logic [1:0] fire_line;
  logic arm;
  assign arm = (st_q == ST_READY) && !manual_q && function_enable;
  // sequences always begin at shot one
  line_start_timer u_start (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .tk(tk),
    .arm(arm),
    .req(req),
    .allowed(shot_line_enable[3:0]), // [R2]
    .delay(line_start_delay[63:0]), // [R3] [R10]
    .fire(fire),
    .fire_line(fire_line)
  );

  // next shot enabled for a line, or 7 if none left
  function automatic logic [2:0] next_shot(input logic [2:0] cur, input logic [1:0] ln,
                                           input logic [19:0] en);
    logic [2:0] r;
    r = 3'h7;
    for (int s = 4; s >= 0; s--)
      if (s > cur && en[s*4 + ln])
        r = 3'(s);
    return r;
  endfunction : next_shot

  function automatic ticks_t pick16(input logic [319:0] v, input logic [2:0] s, input logic [1:0] ln);
    return v[(s*4 + ln)*16 +: 16];
  endfunction : pick16

  ////////////////////////////////////////////////////////////////////////////
  // sequencer next-state
  always_comb
  begin
    logic [2:0] nxt;
    nxt = 3'h0;
    st_d = st_q;
    shot_d = shot_q;
    tmr_d = (tk.tick && tmr_q != 16'h0) ? tmr_q - 16'h1 : tmr_q;
    line_d = line_q;
    kind_d = kind_q;
    manual_d = manual_q;
    ft_cnt_d = (tk.tick && ft_cnt_q != 8'h0) ? ft_cnt_q - 8'h1 : ft_cnt_q;
    ft_d = (ft_cnt_q == 8'h0) ? 5'h00 : ft_q; // [R19]
    starts_d = starts_q;
    fails_d = fails_q;
    for (int i = 0; i < 5; i++)
    begin
      cnt1_d[i] = cnt1_q[i];
      cnt2_d[i] = cnt2_q[i];
    end
    ev_d = 9'h000;
    ev_d[0] = crit_q && !crit; // critical end
    ev_d[4] = function_enable && !ena_q;
    ev_d[5] = !function_enable && ena_q;
    ev_d[3] = tk.tick && ft_cnt_q == 8'h1; // final trip signal ends
    if (!function_enable && st_q != ST_INHIBIT)
      st_d = ST_INHIBIT;
    else
    begin
      case (st_q)
        ST_INIT, ST_INHIBIT:
        begin
          st_d = function_enable ? ST_READY : ST_INHIBIT;
          shot_d = 3'h0;
        end
        ST_READY:
        begin
          if (manual_close)
          begin
            st_d = ST_RECLAIM;
            manual_d = 1'b1;
            kind_d = TMR_RECLAIM;
            tmr_d = reclaim_interval;
          end
          else if (fire)
          begin
            st_d = ST_WAIT_OPEN; // [R11]
            line_d = fire_line;
            kind_d = TMR_START;
            shot_d = 3'h0;
            starts_d = starts_q + 16'h1; // [R8]
            if (fire_line == 2'h0)
              cnt1_d[0] = cnt1_q[0] + 16'h1; // [R9]
            if (fire_line == 2'h1)
              cnt2_d[0] = cnt2_q[0] + 16'h1; // [R9]
          end
          else if (|req)
            kind_d = TMR_START;
        end
        ST_WAIT_OPEN:
        begin
          if (cb_open)
          begin
            st_d = ST_WAIT_CLOSE; // [R12]
            kind_d = TMR_DEAD;
            tmr_d = shot_dead_interval[shot_q*16 +: 16]; // [R1]
          end
        end
        ST_WAIT_CLOSE:
        begin
          if (crit)
            st_d = ST_FINAL_TRIP; // [R20]
          else if (tmr_q == 16'h0 && cb_closed)
          begin
            st_d = ST_DISCRIM; // [R14]
            kind_d = TMR_DISCRIM;
            tmr_d = pick16(line_discrim_interval, shot_q, line_q); // [R4]
          end
        end
        ST_DISCRIM:
        begin
          nxt = next_shot(shot_q, line_q, shot_line_enable);
          if (crit)
            st_d = ST_FINAL_TRIP; // [R20]
          else if (tmr_q == 16'h0)
          begin
            if (!req[line_q])
            begin
              st_d = ST_RECLAIM; // [R16]
              kind_d = TMR_RECLAIM;
              tmr_d = reclaim_interval; // [R17]
            end
            else
            begin
              fails_d = fails_q + 16'h1; // [R8]
              if (nxt == 3'h7)
                st_d = ST_FINAL_TRIP;
              else
              begin
                st_d = ST_WAIT_OPEN; // [R15]
                shot_d = nxt;
                kind_d = TMR_START;
                if (line_q == 2'h0)
                  cnt1_d[nxt] = cnt1_q[nxt] + 16'h1; // [R9]
                if (line_q == 2'h1)
                  cnt2_d[nxt] = cnt2_q[nxt] + 16'h1; // [R9]
              end
            end
          end
        end
        ST_RECLAIM:
        begin
          // requests and critical are ignored while reclaiming
          if (tmr_q == 16'h0)
          begin
            st_d = ST_READY; // [R16] [R17]
            shot_d = 3'h0;
            manual_d = 1'b0;
            ev_d[1] = 1'b1; // release
          end
        end
        ST_FINAL_TRIP:
        begin
          st_d = ST_LOCKED;
          ft_d = 5'h00;
          ft_d[crit ? 3'h4 : {1'b0, line_q}] = 1'b1; // [R19]
          ft_cnt_d = 8'(`FINAL_TRIP_TICKS);
          ev_d[2] = 1'b1; // stopped
          ev_d[6] = crit;
          ev_d[7] = !crit && line_q == 2'h0;
          ev_d[8] = !crit && line_q == 2'h1;
        end
        ST_LOCKED, ST_CB_FAIL:
        begin
          // leave lockout once the breaker is back closed and lines calm
          if (cb_closed && req == 4'h0)
          begin
            st_d = ST_RECLAIM;
            kind_d = TMR_RECLAIM;
            tmr_d = reclaim_interval;
          end
        end
        default:
          st_d = ST_INIT;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= ST_INIT;
      shot_q <= 3'h0;
      tmr_q <= 16'h0;
      line_q <= 2'h0;
      kind_q <= TMR_RECLAIM;
      manual_q <= 1'b0;
      ft_cnt_q <= 8'h0;
      ft_q <= 5'h00;
      starts_q <= 16'h0;
      fails_q <= 16'h0;
      ev_q <= 9'h000;
      ena_q <= 1'b1; // enabled is the idle level, so no false event after reset
      crit_q <= 1'b0;
      for (int i = 0; i < 5; i++)
      begin
        cnt1_q[i] <= 16'h0;
        cnt2_q[i] <= 16'h0;
      end
    end
    else
    begin
      st_q <= st_d;
      shot_q <= shot_d;
      tmr_q <= tmr_d;
      line_q <= line_d;
      kind_q <= kind_d;
      manual_q <= manual_d;
      ft_cnt_q <= ft_cnt_d;
      ft_q <= ft_d;
      starts_q <= starts_d;
      fails_q <= fails_d;
      ev_q <= ev_d;
      ena_q <= function_enable;
      crit_q <= crit;
      for (int i = 0; i < 5; i++)
      begin
        cnt1_q[i] <= cnt1_d[i];
        cnt2_q[i] <= cnt2_d[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign breaker_open_cmd = (st_q == ST_WAIT_OPEN) && !cb_open; // [R11] [R12]
  assign breaker_close_cmd = (st_q == ST_WAIT_CLOSE) && tmr_q == 16'h0 && !cb_closed; // [R13]
  assign state_ind = st_q; // [R21]
  assign timer_kind = kind_q; // [R22]
  assign shot_number = shot_q + 3'h1; // [R7]
  assign total_start_counter = starts_q;
  assign fail_counter = fails_q;
  assign final_trip_sig = ft_q;
  genvar g;
  generate
    for (g = 0; g < 5; g++)
    begin : g_cnt
      assign line_one_shot_counts[g*16 +: 16] = cnt1_q[g];
      assign line_two_shot_counts[g*16 +: 16] = cnt2_q[g];
    end
  endgenerate
  // gated events
  assign critical_end_event = ev_q[0] && soft_event_enable[0]; // [R5]
  assign release_event = ev_q[1] && soft_event_enable[1]; // [R5]
  assign stopped_event = ev_q[2] && soft_event_enable[2]; // [R5]
  assign final_trip_ready_event = ev_q[3] && soft_event_enable[3]; // [R5]
  assign function_enabled_event = ev_q[4] && soft_event_enable[4]; // [R5]
  assign function_disabled_event = ev_q[5] && soft_event_enable[5]; // [R5]
  assign critical_final_trip_event = ev_q[6] && trip_event_enable[0]; // [R6]
  assign line_one_final_trip_event = ev_q[7] && trip_event_enable[1]; // [R6]
  assign line_two_final_trip_event = ev_q[8] && trip_event_enable[2]; // [R6]
endmodule : autoreclose_sequencer
`default_nettype wire

// *** core/autoreclose_defs.svh ***
// Purpose: timing counts and default values for the autoreclose sequencer
// Assumes: ref_clk at 250 MHz, time base of 10 ms
// Notes: all intervals are counted in 10 ms ticks
`ifndef AUTORECLOSE_DEFS_SVH
`define AUTORECLOSE_DEFS_SVH
`define CLK_FREQ_HZ 250000000
`define TICK_MS 10
`define TICK_CYCLES ((`CLK_FREQ_HZ / 1000) * `TICK_MS)
`define TIME_MIN_TICKS 16'd2
`define TIME_MAX_TICKS 16'd30000
`define DEAD_DEFAULT_TICKS 16'd500
`define START_DEFAULT_TICKS 16'd2
`define DISCR_DEFAULT_TICKS 16'd2
`define RECLAIM_DEFAULT_TICKS 16'd1000
`define FINAL_TRIP_MS 500
`define FINAL_TRIP_TICKS (`FINAL_TRIP_MS / `TICK_MS)
`define NUM_SHOTS 5
`define NUM_LINES 4
`define EVT_SOFT_DEFAULT 6'h00
`define EVT_TRIP_DEFAULT 3'h7
`endif

// *** core/autoreclose_pkg.sv ***
// Purpose: types shared by the autoreclose sequencer modules
// Assumes: five shots, four request lines
// Notes: state codes are one-hot
package autoreclose_pkg;
  typedef logic [15:0] ticks_t;
  typedef enum logic [9:0] {
    ST_INIT = 10'h001,
    ST_RECLAIM = 10'h002,
    ST_READY = 10'h004,
    ST_WAIT_OPEN = 10'h008,
    ST_WAIT_CLOSE = 10'h010,
    ST_DISCRIM = 10'h020,
    ST_LOCKED = 10'h040,
    ST_FINAL_TRIP = 10'h080,
    ST_CB_FAIL = 10'h100,
    ST_INHIBIT = 10'h200
  } ar_state_e;
  typedef enum logic [1:0] {
    TMR_RECLAIM = 2'h0,
    TMR_START = 2'h1,
    TMR_DEAD = 2'h2,
    TMR_DISCRIM = 2'h3
  } timer_kind_e;
endpackage : autoreclose_pkg

// *** core/tick_if.sv ***
// Purpose: carries the time-base tick between sequencer modules
// Assumes: one clock domain
// Notes: tick is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface : tick_if
`default_nettype wire

// *** core/tick_divider.sv ***
// Purpose: divides ref_clk down to the 10 ms time-base tick
// Assumes: tick period fits in 32 bits
// Notes: tick is a single-cycle enable, not a clock
`timescale 1ns/1ps
`default_nettype none
`include "autoreclose_defs.svh"
module tick_divider #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic ref_clk, // system clock
  input wire logic rstn, // async reset, active low
  tick_if.src tk // tick out
);
  import autoreclose_pkg::*;
  logic [31:0] cnt_q, cnt_d;
  // wrap counter, tick on terminal count
  always_comb
  begin
    cnt_d = (cnt_q == TICK_CYCLES - 1) ? 32'h0 : cnt_q + 32'h1;
  end
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      cnt_q <= 32'h0;
    else
      cnt_q <= cnt_d;
  end
  assign tk.tick = (cnt_q == TICK_CYCLES - 1);
endmodule : tick_divider
`default_nettype wire

// *** core/line_start_timer.sv ***
// Purpose: per-line start delay counters with priority pick
// Assumes: delay settings already chosen for the running shot
// Notes: a counter restarts whenever its request drops
`timescale 1ns/1ps
`default_nettype none
`include "autoreclose_defs.svh"
module line_start_timer (
  input wire logic ref_clk, // system clock
  input wire logic rstn, // async reset, active low
  tick_if.dst tk, // time base
  input wire logic arm, // counting allowed
  input wire logic [3:0] req, // synchronised requests
  input wire logic [3:0] allowed, // line may start this shot
  input wire logic [63:0] delay, // per-line start delay ticks
  output logic fire, // some delay elapsed
  output logic [1:0] fire_line // winning line index
);
  import autoreclose_pkg::*;
  ticks_t cnt_q [4];
  ticks_t cnt_d [4];
  logic [3:0] done;
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_line
      // count only while the line is requesting and armed
      always_comb
      begin
        if (!(arm && req[g] && allowed[g]))
          cnt_d[g] = 16'h0;
        else if (tk.tick && !done[g])
          cnt_d[g] = cnt_q[g] + 16'h1;
        else
          cnt_d[g] = cnt_q[g];
      end
      always_ff @(posedge ref_clk or negedge rstn)
      begin
        if (!rstn)
          cnt_q[g] <= 16'h0;
        else
          cnt_q[g] <= cnt_d[g];
      end
      assign done[g] = arm && req[g] && allowed[g] && (cnt_q[g] >= delay[g*16 +: 16]);
    end
  endgenerate
  // line one wins ties, line four loses
  always_comb
  begin
    fire = |done; // [R18]
    if (done[0])
      fire_line = 2'h0;
    else if (done[1])
      fire_line = 2'h1;
    else if (done[2])
      fire_line = 2'h2;
    else
      fire_line = 2'h3;
  end
endmodule : line_start_timer
`default_nettype wire

// *** bench/breaker_model.sv ***
// Purpose: circuit breaker partner with a travel delay
// Assumes: commands are levels held until the new position is reported
// Notes: both contacts read low while the breaker travels
`timescale 1ns/1ps
`default_nettype none
module breaker_model #(
  parameter int TRAVEL = 40
) (
  input wire logic ref_clk, // system clock
  input wire logic open_cmd, // open command
  input wire logic close_cmd, // close command
  output logic is_open, // open contact
  output logic is_closed // closed contact
);
  int cnt;
  initial
  begin
    cnt = 0;
    is_open = 1'b0;
    is_closed = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////
  // contacts leave at once, new position only after the travel time
  always @(posedge ref_clk)
  begin
    if ((open_cmd && !is_open) || (close_cmd && !is_closed))
    begin
      is_open <= 1'b0;
      is_closed <= 1'b0;
      cnt <= cnt + 1;
      if (cnt == TRAVEL)
      begin
        is_open <= open_cmd;
        is_closed <= !open_cmd;
        cnt <= 0;
      end
    end
  end
endmodule : breaker_model
`default_nettype wire

// *** bench/autoreclose_sequencer_chk.sv ***
// Purpose: port checker for the autoreclose sequencer
// Assumes: one clock domain, asynchronous active-low reset
// Notes: feedback reaches the logic through a two-stage synchroniser
`timescale 1ns/1ps
`default_nettype none
module autoreclose_sequencer_chk (
  input wire logic ref_clk, // system clock
  input wire logic rstn, // reset, active low
  input wire logic breaker_is_open, // open feedback
  input wire logic breaker_is_closed, // closed feedback
  input wire logic [5:0] soft_event_enable, // soft event enables
  input wire logic [2:0] trip_event_enable, // trip event enables
  input wire logic breaker_open_cmd, // open command
  input wire logic breaker_close_cmd, // close command
  input wire autoreclose_pkg::ar_state_e state_ind, // state
  input wire autoreclose_pkg::timer_kind_e timer_kind, // interval kind
  input wire logic [2:0] shot_number, // running shot
  input wire logic [15:0] total_start_counter, // starts
  input wire logic [15:0] fail_counter, // failed shots
  input wire logic release_event, // release pulse
  input wire logic critical_final_trip_event // critical trip pulse
);
  import autoreclose_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////
  // four cycles cover the synchroniser plus the combinational release
  open_release_a: assert property (breaker_is_open [*4] |-> !breaker_open_cmd)
    else $error("open command held with breaker open");
  close_release_a: assert property (breaker_is_closed [*4] |-> !breaker_close_cmd)
    else $error("close command held with breaker closed");
  close_state_a: assert property (breaker_close_cmd |-> state_ind == ST_WAIT_CLOSE)
    else $error("close command outside dead interval");
  open_state_a: assert property ($rose(breaker_open_cmd) |-> state_ind inside {ST_WAIT_OPEN, ST_FINAL_TRIP})
    else $error("open command from wrong state");
  no_overlap_a: assert property (!(breaker_open_cmd && breaker_close_cmd))
    else $error("open and close commanded together");
  shot_range_a: assert property (shot_number inside {[3'h1:3'h5]})
    else $error("shot number out of range");
  state_onehot_a: assert property ($onehot(state_ind))
    else $error("state indication not one-hot");
  start_step_a: assert property ($changed(total_start_counter) |-> total_start_counter == $past(total_start_counter) + 16'h1)
    else $error("start counter jumped");
  fail_cause_a: assert property ($changed(fail_counter) |-> $past(state_ind) == ST_DISCRIM && fail_counter == $past(fail_counter) + 16'h1)
    else $error("fail counter moved outside discrimination");
  trip_gate_a: assert property (critical_final_trip_event |-> trip_event_enable[0] &&
    state_ind == ST_LOCKED && $past(state_ind) == ST_FINAL_TRIP)
    else $error("critical trip event without final trip or while disabled");
  release_gate_a: assert property (release_event |-> soft_event_enable[1] &&
    state_ind == ST_READY && $past(state_ind) == ST_RECLAIM)
    else $error("release event without reclaim end or while disabled");
  dead_kind_a: assert property (state_ind == ST_WAIT_CLOSE && $past(state_ind) == ST_WAIT_CLOSE |-> timer_kind == TMR_DEAD)
    else $error("dead interval not indicated");
endmodule : autoreclose_sequencer_chk
`default_nettype wire

// *** bench/autoreclose_sequencer_bench.sv ***
// Purpose: self-checking bench for the autoreclose sequencer
// Assumes: every interval set to two ticks of a shortened time base
// Notes: the tick is cut to 100 cycles so the run stays a few thousand cycles
`timescale 1ns/1ps
`default_nettype none
`include "autoreclose_defs.svh"
module autoreclose_sequencer_bench;
  import autoreclose_pkg::*;
  localparam int T = 100;
  logic ref_clk, rstn, function_enable, critical_request, manual_close;
  logic [3:0] request_lines;
  logic breaker_is_open, breaker_is_closed, breaker_open_cmd, breaker_close_cmd;
  logic [79:0] shot_dead_interval, line_one_shot_counts, line_two_shot_counts;
  logic [19:0] shot_line_enable;
  logic [319:0] line_start_delay, line_discrim_interval;
  logic [15:0] reclaim_interval, total_start_counter, fail_counter;
  logic [5:0] soft_event_enable;
  logic [2:0] trip_event_enable, shot_number;
  logic [4:0] final_trip_sig;
  ar_state_e state_ind;
  timer_kind_e timer_kind;
  logic critical_end_event, release_event, stopped_event, final_trip_ready_event;
  logic function_enabled_event, function_disabled_event, critical_final_trip_event;
  logic line_one_final_trip_event, line_two_final_trip_event;
  logic [8:0] ev_seen;
  int err_count, num_checks, n;
  autoreclose_sequencer #(.TICK_CYCLES(T)) i_dut (.*);
  breaker_model #(.TRAVEL(40)) i_brk (.ref_clk(ref_clk), .open_cmd(breaker_open_cmd),
    .close_cmd(breaker_close_cmd), .is_open(breaker_is_open), .is_closed(breaker_is_closed));
  ////////////////////////////////////////////////////////////////////////
  // 250 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // sticky copies, the pulses last a single cycle
  always @(posedge ref_clk)
  begin
    ev_seen <= ev_seen | {line_two_final_trip_event, line_one_final_trip_event, critical_final_trip_event,
      function_disabled_event, function_enabled_event, final_trip_ready_event, stopped_event, release_event,
      critical_end_event};
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // polls settled outputs, bounded so a stuck state cannot hang the run
  task automatic wait_st(input ar_state_e s, input int lim);
    n = 0;
    while (state_ind !== s && n < lim)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(state_ind, s);
  endtask : wait_st
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    err_count = 0;
    num_checks = 0;
    ev_seen = 9'h000;
    rstn = 1'b0;
    function_enable = 1'b1;
    critical_request = 1'b0;
    manual_close = 1'b0;
    request_lines = 4'h0;
    shot_dead_interval = {5{16'h0002}};
    shot_line_enable = 20'h00017;
    line_start_delay = {20{16'h0002}};
    line_discrim_interval = {20{16'h0002}};
    reclaim_interval = 16'h0002;
    soft_event_enable = 6'h36;
    trip_event_enable = 3'h1;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    // single shot, fault gone during discrimination
    @(posedge ref_clk);
    request_lines <= 4'h1;
    wait_st(ST_WAIT_OPEN, 4 * T);
    chk(n >= T, 16'h1);
    chk(breaker_open_cmd, 16'h1);
    chk(shot_number, 16'h1);
    wait_st(ST_WAIT_CLOSE, 1000);
    @(posedge ref_clk);
    #1;
    chk(timer_kind, TMR_DEAD);
    wait_st(ST_DISCRIM, 4 * T);
    chk(n >= T, 16'h1);
    @(posedge ref_clk);
    request_lines <= 4'h0;
    wait_st(ST_RECLAIM, 4 * T);
    wait_st(ST_READY, 4 * T);
    chk(total_start_counter, 16'h1);
    chk(line_one_shot_counts[15:0], 16'h1);
    // the pulse is caught by the sticky copy one edge later
    @(posedge ref_clk);
    #1;
    chk(ev_seen, 16'h0002);
    $display("test 1 done");
    // two lines tie, fault persists into the second shot
    @(posedge ref_clk);
    request_lines <= 4'h3;
    wait_st(ST_DISCRIM, 8 * T);
    wait_st(ST_WAIT_OPEN, 4 * T);
    chk(shot_number, 16'h2);
    chk(fail_counter, 16'h1);
    chk(line_one_shot_counts[15:0], 16'h2);
    chk(line_two_shot_counts[15:0], 16'h0);
    @(posedge ref_clk);
    request_lines <= 4'h0;
    wait_st(ST_RECLAIM, 8 * T);
    wait_st(ST_READY, 4 * T);
    chk(shot_number, 16'h1);
    chk(total_start_counter, 16'h2);
    $display("test 2 done");
    // manual close reclaims, then the function is switched off and on
    @(posedge ref_clk);
    manual_close <= 1'b1;
    @(posedge ref_clk);
    manual_close <= 1'b0;
    #1;
    chk(state_ind, ST_RECLAIM);
    chk(timer_kind, TMR_RECLAIM);
    wait_st(ST_READY, 4 * T);
    @(posedge ref_clk);
    function_enable <= 1'b0;
    wait_st(ST_INHIBIT, 4);
    @(posedge ref_clk);
    function_enable <= 1'b1;
    wait_st(ST_READY, 4);
    $display("manual test done");
    // critical refused when idle, accepted in the dead interval
    @(posedge ref_clk);
    critical_request <= 1'b1;
    repeat (20) @(posedge ref_clk);
    #1;
    chk(state_ind, ST_READY);
    @(posedge ref_clk);
    critical_request <= 1'b0;
    request_lines <= 4'h4;
    wait_st(ST_WAIT_CLOSE, 4 * T);
    @(posedge ref_clk);
    critical_request <= 1'b1;
    repeat (100) @(posedge ref_clk);
    #1;
    chk(final_trip_sig, 16'h0010);
    chk(ev_seen, 16'h0076);
    $display("test 3 done");
    stop_test();
  end
  // watchdog, well past the roughly 30 ticks the tests need
  initial
  begin
    repeat (60 * T) @(posedge ref_clk);
    err_count++;
    stop_test();
  end
endmodule : autoreclose_sequencer_bench
bind autoreclose_sequencer autoreclose_sequencer_chk i_chk (.*);
`default_nettype wire
